// File: shared/dcto_regs.svh
/*
 * timing constants of the dual-channel torque-off monitor.
 * assumes a 250 MHz clk_in; cycle counts are derived from the times.
 */
`ifndef DCTO_REGS_SVH
`define DCTO_REGS_SVH

// ------------------------------------------------------------
// clock
// ------------------------------------------------------------
`define DCTO_CLK_KHZ 250000

// ------------------------------------------------------------
// channel disagreement window, in milliseconds
// ------------------------------------------------------------
`define DCTO_DISC_MIN_MS 1600
`define DCTO_DISC_TYP_MS 2300
`define DCTO_DISC_MAX_MS 3000
`define DCTO_DISC_MIN_CYC (`DCTO_DISC_MIN_MS * `DCTO_CLK_KHZ)
`define DCTO_DISC_TYP_CYC (`DCTO_DISC_TYP_MS * `DCTO_CLK_KHZ)
`define DCTO_DISC_MAX_CYC (`DCTO_DISC_MAX_MS * `DCTO_CLK_KHZ)

// ------------------------------------------------------------
// response window and pulse immunity, in milliseconds
// ------------------------------------------------------------
`define DCTO_RESP_MIN_MS 2
`define DCTO_RESP_TYP_MS 6
`define DCTO_RESP_MAX_MS 10
`define DCTO_PULSE_MS 2
`define DCTO_RESP_MIN_CYC (`DCTO_RESP_MIN_MS * `DCTO_CLK_KHZ)
`define DCTO_RESP_TYP_CYC (`DCTO_RESP_TYP_MS * `DCTO_CLK_KHZ)
`define DCTO_RESP_MAX_CYC (`DCTO_RESP_MAX_MS * `DCTO_CLK_KHZ)
`define DCTO_PULSE_CYC (`DCTO_PULSE_MS * `DCTO_CLK_KHZ)

// ------------------------------------------------------------
// input path
// ------------------------------------------------------------
`define DCTO_SYNC_STAGES 3
`define DCTO_CHAN_RESET 1'h0
`define DCTO_CNT_W 32

`endif

// File: shared/dcto_pkg.sv
/*
 * types of the dual-channel torque-off monitor.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package dcto_pkg;

    // ------------------------------------------------------------
    // channel pair and monitor state
    // ------------------------------------------------------------
    typedef struct packed {
        logic safety_channel_a;
        logic safety_channel_b;
    } dcto_chan_t;

    typedef enum logic [1:0] {
        ST_SAFE,
        ST_RUN,
        ST_DISAGREE,
        ST_FAULT
    } dcto_state_t;

endpackage : dcto_pkg

// File: logic/dcto_input_filter.sv
/*
 * one safety channel: three-flop synchroniser and a level filter that
 * accepts a new level only after it has held for HOLD_CYC cycles.
 * assumes an asynchronous pin on raw_in and a free-running clk_in.
 */
`timescale 1ns/1ps
`include "dcto_regs.svh"

module dcto_input_filter #(
    parameter int HOLD_CYC = `DCTO_RESP_TYP_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic raw_in,
    output logic sampled_out,
    output logic level_out
);
    import dcto_pkg::*;

    localparam logic [`DCTO_CNT_W-1:0] HOLD_M1 = `DCTO_CNT_W'(HOLD_CYC - 1);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic [`DCTO_CNT_W-1:0] hold_cnt_r;

    if (HOLD_CYC < 2) begin : g_bad_hold
        $error("dcto_input_filter: HOLD_CYC too small");
    end

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync1_r <= `DCTO_CHAN_RESET;
            sync2_r <= `DCTO_CHAN_RESET;
            sync3_r <= `DCTO_CHAN_RESET;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ------------------------------------------------------------
    // hold filter
    // ------------------------------------------------------------
    // RULE11: short pulses ignored
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            hold_cnt_r <= '0;
            level_r <= `DCTO_CHAN_RESET;
        end else if (sync2_r == sync3_r && sync3_r != level_r) begin
            if (hold_cnt_r == HOLD_M1) begin
                hold_cnt_r <= '0;
                level_r <= sync3_r;
            end else begin
                hold_cnt_r <= hold_cnt_r + 1'b1;
            end
        end else begin
            hold_cnt_r <= '0;
        end
    end

    assign level_out = level_r;
    assign sampled_out = sync3_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_level_needs_hold: assert property ( // RULE11
        @(posedge clk_in) disable iff (!resetn_in)
        (level_r != $past(level_r)) |-> $past(hold_cnt_r) == HOLD_M1
    ) else $error("channel level changed before hold time");

endmodule : dcto_input_filter

// File: logic/dcto_monitor.sv
/*
 * dual-channel torque-off monitor: filters both safety channels, gives a
 * run enable for the power stage and a safe-state indicator, and latches a
 * fault when the channels disagree for too long.
 * assumes a free-running 250 MHz clk_in and a power-on reset on resetn_in.
 */
//
// Function
// RULE1: both channels low blocks power and starting, reports a trip and turns the indicator on.
// RULE2: both channels high releases the block for software-controlled running with the indicator off.
// RULE3: disagreeing channels keep the drive blocked and the indicator off.
// RULE4: a disagreement past the detection time latches a fault that blocks the drive and holds the indicator off.
// RULE5: a disagreement under 1.6 s never latches a fault, one over 3.0 s always does, 2.3 s typical.
// RULE6: the latched fault is cleared only by a full power cycle, never by inputs or commands.
// RULE7: the time from a first channel going low to torque removal is over 2 ms, typically 6 ms and under 10 ms.
// RULE8: the safety inputs can never be disabled by any mode, setting or command.
// RULE9: the indicator tracks the channels even when only the auxiliary supply powers the drive.
// RULE10: the outside safety equipment switches both channels together with skew well under 1.6 s.
// RULE11: low pulses narrower than 2 ms on either channel are ignored.
// RULE12: channels are sampled on a free-running clock, windows are cycle counters, and the fault clears only at power-on reset.
`timescale 1ns/1ps
`include "dcto_regs.svh"

module dcto_monitor #(
    parameter int DISC_CYC = `DCTO_DISC_TYP_CYC,
    parameter int HOLD_CYC = `DCTO_RESP_TYP_CYC,
    parameter int DISC_MIN_CYC = `DCTO_DISC_MIN_CYC,
    parameter int DISC_MAX_CYC = `DCTO_DISC_MAX_CYC,
    parameter int PULSE_CYC = `DCTO_PULSE_CYC,
    parameter int RESP_MAX_CYC = `DCTO_RESP_MAX_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input dcto_pkg::dcto_chan_t safety_channels_in,
    output logic run_enable_out,
    output logic torque_off_trip_out,
    output logic safe_state_indicator_out,
    output logic fault_latched_out,
    output dcto_pkg::dcto_state_t state_out
);
    import dcto_pkg::*;

    localparam logic [`DCTO_CNT_W-1:0] DISC_M1 = `DCTO_CNT_W'(DISC_CYC - 1);
    localparam logic [`DCTO_CNT_W-1:0] DISC_MIN_M1 =
        `DCTO_CNT_W'(DISC_MIN_CYC - 1);
    localparam logic [`DCTO_CNT_W-1:0] RESP_MAX =
        `DCTO_CNT_W'(RESP_MAX_CYC);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (DISC_CYC < DISC_MIN_CYC || DISC_CYC > DISC_MAX_CYC ||
        DISC_CYC < 2) begin : g_bad_disc
        $error("dcto_monitor: DISC_CYC outside detection window");
    end
    if (HOLD_CYC <= PULSE_CYC ||
        HOLD_CYC + `DCTO_SYNC_STAGES + 2 >= RESP_MAX_CYC) begin : g_bad_hold
        $error("dcto_monitor: HOLD_CYC outside response window");
    end

    dcto_chan_t filt;
    dcto_chan_t samp;
    dcto_state_t state_r;
    dcto_state_t state_nxt;
    logic [`DCTO_CNT_W-1:0] disc_cnt_r;
    logic disagree;

    // ------------------------------------------------------------
    // channel filters
    // ------------------------------------------------------------
    // RULE12: sampled on free-running clock
    dcto_input_filter #(
        .HOLD_CYC(HOLD_CYC)
    ) u_filter_a (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .raw_in(safety_channels_in.safety_channel_a),
        .sampled_out(samp.safety_channel_a),
        .level_out(filt.safety_channel_a)
    );

    dcto_input_filter #(
        .HOLD_CYC(HOLD_CYC)
    ) u_filter_b (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .raw_in(safety_channels_in.safety_channel_b),
        .sampled_out(samp.safety_channel_b),
        .level_out(filt.safety_channel_b)
    );

    assign disagree = filt.safety_channel_a != filt.safety_channel_b;

    // ------------------------------------------------------------
    // discrepancy counter
    // ------------------------------------------------------------
    // RULE12: counter cleared on agreement
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            disc_cnt_r <= '0;
        end else if (disagree && state_r != ST_FAULT &&
                     disc_cnt_r != DISC_M1) begin
            disc_cnt_r <= disc_cnt_r + 1'b1;
        end else begin
            disc_cnt_r <= '0;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    // RULE8: no term can bypass the channels
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // RULE4: fault latch holds
            // RULE6: only reset leaves fault
            ST_FAULT: begin
                state_nxt = ST_FAULT;
            end
            default: begin
                if (disagree) begin
                    // RULE5: fault after detection time
                    if (disc_cnt_r == DISC_M1) begin
                        state_nxt = ST_FAULT;
                    end else begin
                        state_nxt = ST_DISAGREE;
                    end
                end else if (filt.safety_channel_a) begin
                    state_nxt = ST_RUN;
                end else begin
                    state_nxt = ST_SAFE;
                end
            end
        endcase
    end

    // RULE12: fault cleared only at reset
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= ST_SAFE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // RULE2: run only with both high
    // RULE7: block follows filtered low
    assign run_enable_out = state_r == ST_RUN;
    // RULE1: trip while blocked
    // RULE3: disagreement stays blocked
    assign torque_off_trip_out = state_r != ST_RUN;
    // RULE1: indicator on in safe state
    // RULE9: indicator has no supply term
    assign safe_state_indicator_out = state_r == ST_SAFE;
    assign fault_latched_out = state_r == ST_FAULT;
    assign state_out = state_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [`DCTO_CNT_W-1:0] resp_cnt_r;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            resp_cnt_r <= '0;
        end else if (run_enable_out &&
                     !(samp.safety_channel_a && samp.safety_channel_b)) begin
            resp_cnt_r <= resp_cnt_r + 1'b1;
        end else begin
            resp_cnt_r <= '0;
        end
    end

    a_safe_both_low: assert property ( // RULE1
        @(posedge clk_in) disable iff (!resetn_in)
        (!filt.safety_channel_a && !filt.safety_channel_b &&
         state_r != ST_FAULT) |=>
        safe_state_indicator_out && torque_off_trip_out && !run_enable_out
    ) else $error("both channels low but not in safe state");

    a_run_both_high: assert property ( // RULE2
        @(posedge clk_in) disable iff (!resetn_in)
        run_enable_out |-> $past(filt.safety_channel_a) &&
        $past(filt.safety_channel_b) && !safe_state_indicator_out
    ) else $error("run enabled without both channels high");

    a_disagree_blocks: assert property ( // RULE3
        @(posedge clk_in) disable iff (!resetn_in)
        disagree |=> !run_enable_out && !safe_state_indicator_out
    ) else $error("disagreeing channels did not block the drive");

    a_fault_holds: assert property ( // RULE4
        @(posedge clk_in) disable iff (!resetn_in)
        fault_latched_out |=> fault_latched_out && !run_enable_out &&
        !safe_state_indicator_out
    ) else $error("latched fault released or outputs wrong");

    a_fault_on_time: assert property ( // RULE5
        @(posedge clk_in) disable iff (!resetn_in)
        (disagree && disc_cnt_r == DISC_M1) |=> fault_latched_out
    ) else $error("fault not latched at detection time");

    a_no_early_fault: assert property ( // RULE5
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(fault_latched_out) |-> $past(disc_cnt_r) >= DISC_MIN_M1
    ) else $error("fault latched before minimum detection time");

    a_fault_no_exit: assert property ( // RULE6
        @(posedge clk_in) disable iff (!resetn_in)
        fault_latched_out ##1 (filt.safety_channel_a &&
        filt.safety_channel_b) |=> state_r == ST_FAULT
    ) else $error("inputs released a latched fault");

    a_response_bound: assert property ( // RULE7
        @(posedge clk_in) disable iff (!resetn_in)
        resp_cnt_r < RESP_MAX
    ) else $error("torque block slower than response limit");

    a_indicator_track: assert property ( // RULE9
        @(posedge clk_in) disable iff (!resetn_in)
        safe_state_indicator_out |-> $past(!filt.safety_channel_a) &&
        $past(!filt.safety_channel_b)
    ) else $error("indicator on without both channels low");

    a_disc_clear: assert property ( // RULE12
        @(posedge clk_in) disable iff (!resetn_in)
        !disagree |=> disc_cnt_r == '0
    ) else $error("discrepancy counter not cleared on agreement");

    c_run: cover property (
        @(posedge clk_in) disable iff (!resetn_in)
        state_r == ST_SAFE ##1 state_r == ST_RUN
    );

    c_skew_ok: cover property (
        @(posedge clk_in) disable iff (!resetn_in)
        state_r == ST_DISAGREE ##1 state_r == ST_RUN
    );

    c_fault: cover property (
        @(posedge clk_in) disable iff (!resetn_in)
        state_r == ST_DISAGREE ##1 state_r == ST_FAULT
    );

    c_run_to_safe: cover property (
        @(posedge clk_in) disable iff (!resetn_in)
        state_r == ST_RUN ##1 state_r == ST_SAFE
    );

endmodule : dcto_monitor

// File: verification/dcto_safety_source.sv
/*
 * model of the outside safety equipment that drives both channels.
 * assumes the bench sets want_in just after a rising edge of clk_in.
 */
`timescale 1ns/1ps

module dcto_safety_source (
    input wire logic clk_in,
    input dcto_pkg::dcto_chan_t want_in,
    output dcto_pkg::dcto_chan_t chan_out
);
    import dcto_pkg::*;

    initial begin
        chan_out = '0;
    end

    // channels switch together
    // both channels follow the request on the same edge; any skew is the
    // bench's own choice: below the minimum detection time in test_skew, past it in test_fault_latch
    always @(posedge clk_in) begin
        chan_out <= want_in;
    end
endmodule : dcto_safety_source

// File: verification/dcto_monitor_test.sv
/*
 * self-checking bench of the torque-off monitor with shortened counts.
 * assumes the design and its package are compiled before this file.
 */
`timescale 1ns/1ps

`define CHECK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end

module dcto_monitor_test;
    import dcto_pkg::*;

    localparam int HOLD = 8;
    localparam int DISC = 40;
    localparam int PULSE = 4;
    localparam int RESP_MAX = 20;
    localparam int DISC_MIN = 30;
    localparam int DISC_MAX = 50;

    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    dcto_chan_t want = '0;
    dcto_chan_t chan;
    logic run_enable_out;
    logic torque_off_trip_out;
    logic safe_state_indicator_out;
    logic fault_latched_out;
    dcto_state_t state_out;
    int err_count = 0;
    int check_count = 0;
    int n;

    always #2 clk_in = ~clk_in;

    dcto_safety_source src_u (
        .clk_in(clk_in),
        .want_in(want),
        .chan_out(chan)
    );

    dcto_monitor #(
        .DISC_CYC(DISC), .HOLD_CYC(HOLD), .DISC_MIN_CYC(DISC_MIN),
        .DISC_MAX_CYC(DISC_MAX), .PULSE_CYC(PULSE), .RESP_MAX_CYC(RESP_MAX)
    ) dut_u (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .safety_channels_in(chan),
        .run_enable_out(run_enable_out),
        .torque_off_trip_out(torque_off_trip_out),
        .safe_state_indicator_out(safe_state_indicator_out),
        .fault_latched_out(fault_latched_out),
        .state_out(state_out)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic set_pins(input logic a, input logic b);
        @(posedge clk_in);
        want.safety_channel_a <= a;
        want.safety_channel_b <= b;
    endtask : set_pins

    task automatic wait_state(input dcto_state_t s, input int lim);
        n = 0;
        @(negedge clk_in);
        while (state_out !== s && n < lim) begin
            @(negedge clk_in);
            n++;
        end
    endtask : wait_state

    // outputs against run, trip, indicator, fault
    task automatic check_outs(input logic [3:0] exp);
        `CHECK({run_enable_out, torque_off_trip_out,
                safe_state_indicator_out, fault_latched_out}, exp)
    endtask : check_outs

    task automatic do_reset();
        @(posedge clk_in);
        resetn_in <= 1'b0;
        want <= '0;
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        `CHECK(state_out, ST_SAFE)
        check_outs(4'h6);
    endtask : do_reset

    task automatic test_run_and_stop();
        set_pins(1'b1, 1'b1);
        wait_state(ST_RUN, 4 * RESP_MAX);
        `CHECK(n > PULSE && n <= RESP_MAX, 1'b1)
        check_outs(4'h8);
        set_pins(1'b0, 1'b0);
        wait_state(ST_SAFE, 4 * RESP_MAX);
        `CHECK(n > PULSE && n <= RESP_MAX, 1'b1)
        check_outs(4'h6);
    endtask : test_run_and_stop

    task automatic test_pulse_immunity();
        set_pins(1'b1, 1'b1);
        wait_state(ST_RUN, 4 * RESP_MAX);
        set_pins(1'b0, 1'b1);
        repeat (PULSE - 1) @(posedge clk_in);
        want.safety_channel_a <= 1'b1;
        set_pins(1'b1, 1'b0);
        repeat (PULSE - 1) @(posedge clk_in);
        want.safety_channel_b <= 1'b1;
        repeat (3 * RESP_MAX) begin
            @(negedge clk_in);
            `CHECK(state_out, ST_RUN)
        end
        set_pins(1'b0, 1'b0);
        wait_state(ST_SAFE, 4 * RESP_MAX);
        check_outs(4'h6);
    endtask : test_pulse_immunity

    task automatic test_skew();
        set_pins(1'b1, 1'b0);
        wait_state(ST_DISAGREE, 4 * RESP_MAX);
        `CHECK(state_out, ST_DISAGREE)
        check_outs(4'h4);
        repeat (DISC_MIN - 16) @(posedge clk_in);
        want.safety_channel_b <= 1'b1;
        wait_state(ST_RUN, 4 * RESP_MAX);
        `CHECK(state_out, ST_RUN)
        check_outs(4'h8);
    endtask : test_skew

    task automatic test_fault_latch();
        set_pins(1'b0, 1'b1);
        wait_state(ST_FAULT, 4 * DISC_MAX);
        // filter latency is HOLD + 4 cycles before the disagreement starts
        `CHECK(n >= DISC_MIN + HOLD + 4 && n <= DISC_MAX + HOLD + 6, 1'b1)
        check_outs(4'h5);
        set_pins(1'b0, 1'b0);
        repeat (3 * RESP_MAX) @(posedge clk_in);
        set_pins(1'b1, 1'b1);
        repeat (3 * RESP_MAX) @(posedge clk_in);
        @(negedge clk_in);
        `CHECK(state_out, ST_FAULT)
        check_outs(4'h5);
        do_reset();
        `CHECK(fault_latched_out, 1'b0)
        set_pins(1'b1, 1'b1);
        wait_state(ST_RUN, 4 * RESP_MAX);
        `CHECK(state_out, ST_RUN)
    endtask : test_fault_latch

    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        `CHECK(state_out, ST_SAFE)
        check_outs(4'h6);
        test_run_and_stop();
        test_pulse_immunity();
        test_skew();
        set_pins(1'b0, 1'b0);
        wait_state(ST_SAFE, 4 * RESP_MAX);
        check_outs(4'h6);
        test_fault_latch();
        give_verdict();
    end

    // watchdog sized well above the whole sequence
    initial begin
        #(4 * 20000);
        err_count++;
        give_verdict();
    end
endmodule : dcto_monitor_test
